/* File: rtl/maap_policy.sv */
// Memory attribute access policy: faults, deferral, prefetch, flush, tracking
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/10ps
module maap_policy
   import maap_pkg::*;
#(
   parameter int ENTRIES = 8,
   parameter int TREG_W  = 7,
   parameter int ADDR_W  = 48,
   parameter int SIZE_W  = 4
) (
   input  wire logic              core_clk,
   input  wire logic              srst,
   // Register port
   input  wire logic [REG_AW-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [DATA_W-1:0]      reg_rdata,
   // Memory reference request
   input  wire logic              req_valid,
   input  wire maap_op_t          req_op,
   input  wire maap_attr_t        req_attr,
   input  wire logic              req_ext,
   input  wire logic              req_lower_fault,
   input  wire logic [TREG_W-1:0] req_treg,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [SIZE_W-1:0] req_size,
   // Response
   output logic                   resp_valid,
   output maap_fault_t            resp_fault,
   output logic                   resp_deferred,
   output logic                   resp_base_update,
   output logic                   mem_issue,
   output logic                   prefetch_drop,
   output logic                   flush_bcast,
   output logic                   atomic_export,
   output logic                   track_alloc,
   output logic                   track_remove,
   // Global translation purge
   input  wire logic              purge_req,
   input  wire logic              wb_flush_done,
   output logic                   tlb_purge,
   output logic                   wb_flush_req,
   output logic                   purge_done
);

   localparam int OCC_W = $clog2(ENTRIES + 1);

   typedef struct packed {
      logic [2:0]        ctrl;
      logic [0:0]        defer;
      logic [DATA_W-1:0] rdata;
      logic              resp_valid;
      maap_fault_t       resp_fault;
      logic              resp_deferred;
      logic              resp_base_update;
      logic              mem_issue;
      logic              prefetch_drop;
      logic              flush_bcast;
      logic              atomic_export;
      logic              track_alloc;
      logic              track_remove;
      maap_pg_state_t    pg_state;
      logic              tlb_purge;
      logic              wb_flush_req;
      logic              purge_done;
   } maap_state_t;

   maap_state_t state_reg;
   maap_state_t state_next;

   logic             tt_reg_hit;
   logic             tt_exact_hit;
   logic [OCC_W-1:0] tt_occ;
   logic             cmd_alloc;
   logic             cmd_remove;

   // Decoded request class
   logic is_spec;
   logic is_nap;
   logic is_wb;
   logic is_adv;
   logic is_chk;
   logic is_data;
   logic nap_fault;
   logic unsup_fault;
   logic ext_unsup;
   logic deferred;
   logic lower_fault;
   logic export_ok;
   logic faulted;

   always_comb begin
      is_spec = (req_op == MAAP_OP_SPEC_LD) || (req_op == MAAP_OP_SADV_LD);
      is_nap  = (req_attr == MAAP_ATTR_NAP);
      is_wb   = maap_is_wb(req_attr);
      is_adv  = (req_op == MAAP_OP_ADV_LD) || (req_op == MAAP_OP_SADV_LD);
      is_chk  = (req_op == MAAP_OP_CHK_CLR) || (req_op == MAAP_OP_CHK_NC);
      is_data = (req_op != MAAP_OP_FLUSH) && (req_op != MAAP_OP_PREFETCH);

      // Non-speculative references other than flush and prefetch to a no-access page fault
      nap_fault = is_nap && is_data && !is_spec;

      // Ten-byte access outside write-back pages, unsupported unless CTRL_EXT_SUP_BIT is set
      ext_unsup = req_ext && !is_wb && !is_nap
                  && !state_reg.ctrl[CTRL_EXT_SUP_BIT];

      export_ok = (req_attr == MAAP_ATTR_XUC)
                  && state_reg.ctrl[CTRL_EXPORT_SUP_BIT];

      unsup_fault = 1'b0;
      unique case (req_op)
         MAAP_OP_CMPXCHG,
         MAAP_OP_XCHG: begin
            unsup_fault = !is_nap && (req_attr != MAAP_ATTR_WB);
         end
         MAAP_OP_FETCHADD: begin
            unsup_fault = !is_nap && (req_attr != MAAP_ATTR_WB) && !export_ok;
         end
         MAAP_OP_SPEC_LD,
         MAAP_OP_SADV_LD: begin
            unsup_fault = 1'b0;
         end
         default: begin
            unsup_fault = ext_unsup && is_data;
         end
      endcase

      // Speculative loads defer no-access and unsupported ten-byte faults
      deferred = is_spec && (is_nap || ext_unsup);
      // Lower faults defer only when the deferral register says so
      lower_fault = req_lower_fault && is_data && !nap_fault && !unsup_fault
                    && !(is_spec && state_reg.defer[DEFER_LOWER_BIT]);
      if (is_spec && req_lower_fault && state_reg.defer[DEFER_LOWER_BIT]) begin
         deferred = 1'b1;
      end

      faulted = nap_fault || unsup_fault || lower_fault;
   end

   // Tracking table commands act on the same request
   always_comb begin
      cmd_alloc  = 1'b0;
      cmd_remove = 1'b0;
      if (req_valid && !faulted) begin
         unique case (req_op)
            MAAP_OP_ADV_LD: begin
               cmd_alloc  = maap_is_spec_page(req_attr);
               cmd_remove = !maap_is_spec_page(req_attr);
            end
            MAAP_OP_SADV_LD: begin
               // Limited pages count as non-speculative here
               cmd_alloc  = (req_attr == MAAP_ATTR_WB) && !deferred;
               cmd_remove = !cmd_alloc;
            end
            MAAP_OP_CHK_CLR: begin
               cmd_remove = maap_is_spec_page(req_attr) && tt_reg_hit;
            end
            MAAP_OP_CHK_NC: begin
               if (maap_is_spec_page(req_attr)) begin
                  cmd_alloc = !tt_reg_hit
                              || (!tt_exact_hit && state_reg.ctrl[CTRL_PARTIAL_BIT]);
               end
            end
            default: begin
               cmd_alloc  = 1'b0;
               cmd_remove = 1'b0;
            end
         endcase
      end
   end

   maap_track_table #(
      .ENTRIES (ENTRIES),
      .TREG_W  (TREG_W),
      .ADDR_W  (ADDR_W),
      .SIZE_W  (SIZE_W)
   ) u_track (
      .core_clk   (core_clk),
      .srst       (srst),
      .treg       (req_treg),
      .addr       (req_addr),
      .size       (req_size),
      .cmd_alloc  (cmd_alloc),
      .cmd_remove (cmd_remove),
      .reg_hit    (tt_reg_hit),
      .exact_hit  (tt_exact_hit),
      .occupancy  (tt_occ)
   );

   always_comb begin
      state_next = state_reg;

      // Register port
      if (reg_wr) begin
         unique case (reg_addr)
            REG_CTRL: begin
               state_next.ctrl = reg_wdata[2:0];
            end
            REG_DEFER: begin
               state_next.defer = reg_wdata[0:0];
            end
            default: begin
               state_next.ctrl = state_reg.ctrl;
            end
         endcase
      end
      state_next.rdata = '0;
      if (reg_rd) begin
         unique case (reg_addr)
            REG_CTRL: begin
               state_next.rdata[2:0] = state_reg.ctrl;
            end
            REG_DEFER: begin
               state_next.rdata[0:0] = state_reg.defer;
            end
            REG_STATUS: begin
               state_next.rdata[STAT_BUSY_BIT] = (state_reg.pg_state != MAAP_PG_IDLE);
               state_next.rdata[STAT_OCC_LSB +: OCC_W] = tt_occ;
            end
            default: begin
               state_next.rdata = '0;
            end
         endcase
      end

      // Reference response, one cycle after the request
      state_next.resp_valid       = req_valid;
      state_next.resp_fault       = MAAP_FLT_NONE;
      state_next.resp_deferred    = 1'b0;
      state_next.resp_base_update = 1'b0;
      state_next.mem_issue        = 1'b0;
      state_next.prefetch_drop    = 1'b0;
      state_next.flush_bcast      = 1'b0;
      state_next.atomic_export    = 1'b0;
      state_next.track_alloc      = cmd_alloc;
      state_next.track_remove     = cmd_remove;
      if (req_valid) begin
         if (nap_fault) begin
            state_next.resp_fault = MAAP_FLT_NAP;
         end else if (unsup_fault) begin
            state_next.resp_fault = MAAP_FLT_UNSUP;
         end else if (lower_fault) begin
            state_next.resp_fault = MAAP_FLT_LOWER;
         end
         state_next.resp_deferred    = deferred && !faulted;
         // Post-increment still happens on a deferred load
         state_next.resp_base_update = !faulted;
         unique case (req_op)
            MAAP_OP_FLUSH: begin
               state_next.flush_bcast = 1'b1;
            end
            MAAP_OP_PREFETCH: begin
               state_next.prefetch_drop = !maap_is_cacheable(req_attr);
               state_next.mem_issue     = maap_is_cacheable(req_attr);
            end
            MAAP_OP_FETCHADD: begin
               state_next.atomic_export = !faulted && export_ok;
               state_next.mem_issue     = !faulted;
            end
            default: begin
               // Deferred load aborts its memory access
               state_next.mem_issue = !faulted && !deferred;
            end
         endcase
      end

      // Global translation purge sequence
      state_next.tlb_purge  = 1'b0;
      state_next.purge_done = 1'b0;
      unique case (state_reg.pg_state)
         MAAP_PG_IDLE: begin
            if (purge_req) begin
               state_next.tlb_purge    = 1'b1;
               state_next.wb_flush_req = 1'b1;
               state_next.pg_state     = MAAP_PG_FLUSH;
            end
         end
         MAAP_PG_FLUSH: begin
            if (wb_flush_done) begin
               state_next.wb_flush_req = 1'b0;
               state_next.pg_state     = MAAP_PG_DONE;
            end
         end
         MAAP_PG_DONE: begin
            state_next.purge_done = 1'b1;
            state_next.pg_state   = MAAP_PG_IDLE;
         end
         default: begin
            state_next.wb_flush_req = 1'b0;
            state_next.pg_state     = MAAP_PG_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_reg       <= '0;
         state_reg.ctrl  <= CTRL_RESET;
         state_reg.defer <= DEFER_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign reg_rdata        = state_reg.rdata;
   assign resp_valid       = state_reg.resp_valid;
   assign resp_fault       = state_reg.resp_fault;
   assign resp_deferred    = state_reg.resp_deferred;
   assign resp_base_update = state_reg.resp_base_update;
   assign mem_issue        = state_reg.mem_issue;
   assign prefetch_drop    = state_reg.prefetch_drop;
   assign flush_bcast      = state_reg.flush_bcast;
   assign atomic_export    = state_reg.atomic_export;
   assign track_alloc      = state_reg.track_alloc;
   assign track_remove     = state_reg.track_remove;
   assign tlb_purge        = state_reg.tlb_purge;
   assign wb_flush_req     = state_reg.wb_flush_req;
   assign purge_done       = state_reg.purge_done;

endmodule

/* File: rtl/maap_pkg.sv */
// Constants, types and helpers for the memory attribute access policy block
package maap_pkg;

   localparam int REG_AW  = 4;
   localparam int DATA_W  = 32;

   // Register byte offsets
   localparam logic [REG_AW-1:0] REG_CTRL   = 4'h0;
   localparam logic [REG_AW-1:0] REG_DEFER  = 4'h4;
   localparam logic [REG_AW-1:0] REG_STATUS = 4'h8;

   // Control register fields
   localparam int CTRL_EXT_SUP_BIT    = 0;
   localparam int CTRL_EXPORT_SUP_BIT = 1;
   localparam int CTRL_PARTIAL_BIT    = 2;
   localparam logic [2:0] CTRL_RESET  = 3'h0;

   // Deferral register fields
   localparam int DEFER_LOWER_BIT     = 0;
   localparam logic [0:0] DEFER_RESET = 1'h0;

   // Status register fields
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_OCC_LSB  = 8;

   typedef enum logic [2:0] {
      MAAP_ATTR_WB   = 3'h0,
      MAAP_ATTR_WBL  = 3'h1,
      MAAP_ATTR_UC   = 3'h2,
      MAAP_ATTR_XUC  = 3'h3,
      MAAP_ATTR_WC   = 3'h4,
      MAAP_ATTR_NAP  = 3'h5
   } maap_attr_t;

   typedef enum logic [3:0] {
      MAAP_OP_FETCH    = 4'h0,
      MAAP_OP_LOAD     = 4'h1,
      MAAP_OP_STORE    = 4'h2,
      MAAP_OP_SPEC_LD  = 4'h3,
      MAAP_OP_ADV_LD   = 4'h4,
      MAAP_OP_SADV_LD  = 4'h5,
      MAAP_OP_CHK_CLR  = 4'h6,
      MAAP_OP_CHK_NC   = 4'h7,
      MAAP_OP_CMPXCHG  = 4'h8,
      MAAP_OP_XCHG     = 4'h9,
      MAAP_OP_FETCHADD = 4'ha,
      MAAP_OP_FLUSH    = 4'hb,
      MAAP_OP_PREFETCH = 4'hc
   } maap_op_t;

   typedef enum logic [1:0] {
      MAAP_FLT_NONE  = 2'h0,
      MAAP_FLT_NAP   = 2'h1,
      MAAP_FLT_UNSUP = 2'h2,
      MAAP_FLT_LOWER = 2'h3
   } maap_fault_t;

   typedef enum logic [1:0] {
      MAAP_PG_IDLE  = 2'b00,
      MAAP_PG_FLUSH = 2'b01,
      MAAP_PG_DONE  = 2'b11
   } maap_pg_state_t;

   function automatic logic maap_is_wb(input maap_attr_t a);
      return (a == MAAP_ATTR_WB) || (a == MAAP_ATTR_WBL);
   endfunction

   function automatic logic maap_is_cacheable(input maap_attr_t a);
      return maap_is_wb(a);
   endfunction

   function automatic logic maap_is_spec_page(input maap_attr_t a);
      return maap_is_wb(a);
   endfunction

endpackage

/* File: rtl/maap_track_table.sv */
// Advanced load tracking table with register, address and size entries
`timescale 1ns/10ps
module maap_track_table
   import maap_pkg::*;
#(
   parameter int ENTRIES = 8,
   parameter int TREG_W  = 7,
   parameter int ADDR_W  = 48,
   parameter int SIZE_W  = 4,
   parameter int IDX_W   = $clog2(ENTRIES),
   parameter int OCC_W   = $clog2(ENTRIES + 1)
) (
   input  wire logic              core_clk,
   input  wire logic              srst,
   input  wire logic [TREG_W-1:0] treg,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [SIZE_W-1:0] size,
   input  wire logic              cmd_alloc,
   input  wire logic              cmd_remove,
   output logic                   reg_hit,
   output logic                   exact_hit,
   output logic [OCC_W-1:0]       occupancy
);

   typedef struct packed {
      logic              valid;
      logic [TREG_W-1:0] treg;
      logic [ADDR_W-1:0] addr;
      logic [SIZE_W-1:0] size;
   } maap_entry_t;

   typedef struct packed {
      maap_entry_t [ENTRIES-1:0] ent;
      logic [IDX_W-1:0]          victim;
   } maap_tt_state_t;

   maap_tt_state_t state_reg;
   maap_tt_state_t state_next;

   always_comb begin
      logic             found_reg;
      logic             found_free;
      logic [IDX_W-1:0] reg_idx;
      logic [IDX_W-1:0] free_idx;
      logic [IDX_W-1:0] slot;
      found_reg  = 1'b0;
      found_free = 1'b0;
      reg_idx    = '0;
      free_idx   = '0;
      slot       = '0;
      reg_hit    = 1'b0;
      exact_hit  = 1'b0;
      occupancy  = '0;
      state_next = state_reg;
      for (int i = 0; i < ENTRIES; i++) begin
         if (state_reg.ent[i].valid) begin
            occupancy = OCC_W'(occupancy + 1'b1);
            if (state_reg.ent[i].treg == treg) begin
               found_reg = 1'b1;
               reg_idx   = IDX_W'(i);
               if (state_reg.ent[i].addr == addr && state_reg.ent[i].size == size) begin
                  exact_hit = 1'b1;
               end
            end
         end else if (!found_free) begin
            found_free = 1'b1;
            free_idx   = IDX_W'(i);
         end
      end
      reg_hit = found_reg;
      // One entry per register: reuse a register match before a free slot
      if (cmd_alloc) begin
         slot = found_reg ? reg_idx : (found_free ? free_idx : state_reg.victim);
         state_next.ent[slot] = '{valid: 1'b1, treg: treg, addr: addr, size: size};
         if (!found_reg && !found_free) begin
            state_next.victim = (state_reg.victim == IDX_W'(ENTRIES - 1)) ? '0
                              : IDX_W'(state_reg.victim + 1'b1);
         end
      end else if (cmd_remove && found_reg) begin
         state_next.ent[reg_idx].valid = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

endmodule

/* File: testbench/maap_policy_assertions.sv */
// Port-level checker for the memory attribute access policy block
`timescale 1ns/10ps
module maap_policy_assertions
   import maap_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        srst,
   input wire logic        req_valid,
   input wire maap_op_t    req_op,
   input wire maap_attr_t  req_attr,
   input wire logic        req_lower_fault,
   input wire logic        resp_valid,
   input wire maap_fault_t resp_fault,
   input wire logic        resp_deferred,
   input wire logic        resp_base_update,
   input wire logic        mem_issue,
   input wire logic        prefetch_drop,
   input wire logic        flush_bcast,
   input wire logic        track_alloc,
   input wire logic        track_remove,
   input wire logic        purge_req,
   input wire logic        wb_flush_done,
   input wire logic        tlb_purge,
   input wire logic        wb_flush_req,
   input wire logic        purge_done
);
   logic pg_busy;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);

   // Purge in flight, from accepted request to completion pulse
   always_ff @(posedge core_clk) begin
      pg_busy <= !srst && !purge_done && (pg_busy || purge_req);
   end

   sequence s_done_seen;
      wb_flush_req && wb_flush_done;
   endsequence
   sequence s_purge_close;
      !wb_flush_req ##1 purge_done;
   endsequence

   a_resp_one_later:
      assert property (resp_valid == $past(req_valid)) else $error("response not one cycle late");
   a_nap_fault:
      assert property (req_valid && req_attr == MAAP_ATTR_NAP && req_op inside {MAAP_OP_FETCH,
         MAAP_OP_LOAD, MAAP_OP_STORE, MAAP_OP_CMPXCHG, MAAP_OP_XCHG, MAAP_OP_FETCHADD}
         |=> resp_fault == MAAP_FLT_NAP && !mem_issue && !resp_base_update)
      else $error("no-access fault missing");
   a_spec_defer:
      assert property (req_valid && !req_lower_fault && req_attr == MAAP_ATTR_NAP
         && req_op inside {MAAP_OP_SPEC_LD, MAAP_OP_SADV_LD}
         |=> resp_deferred && resp_base_update && !mem_issue && !track_alloc)
      else $error("speculative load not deferred");
   a_xchg_unsup:
      assert property (req_valid && req_op inside {MAAP_OP_CMPXCHG, MAAP_OP_XCHG}
         && !(req_attr inside {MAAP_ATTR_WB, MAAP_ATTR_NAP}) |=> resp_fault == MAAP_FLT_UNSUP)
      else $error("exchange not refused");
   a_flush_bcast:
      assert property (req_valid && req_op == MAAP_OP_FLUSH
         |=> flush_bcast && resp_fault == MAAP_FLT_NONE && !mem_issue)
      else $error("flush not broadcast");
   a_prefetch_drop:
      assert property (req_valid && req_op == MAAP_OP_PREFETCH
         && !(req_attr inside {MAAP_ATTR_WB, MAAP_ATTR_WBL})
         |=> prefetch_drop && !mem_issue && resp_fault == MAAP_FLT_NONE)
      else $error("prefetch not dropped");
   a_fault_no_track:
      assert property (resp_valid && resp_fault != MAAP_FLT_NONE
         |-> !mem_issue && !track_alloc && !track_remove)
      else $error("faulted reference had effects");
   a_purge_start:
      assert property (purge_req && !pg_busy |=> tlb_purge && wb_flush_req)
      else $error("purge not started");
   a_purge_close:
      assert property (s_done_seen |=> s_purge_close) else $error("purge close wrong");
   a_flush_held:
      assert property (wb_flush_req && !wb_flush_done |=> wb_flush_req)
      else $error("flush request dropped early");
endmodule

bind maap_policy maap_policy_assertions u_chk (.core_clk, .srst, .req_valid, .req_op, .req_attr,
   .resp_valid, .resp_fault, .resp_deferred, .resp_base_update, .mem_issue, .prefetch_drop,
   .flush_bcast, .track_alloc, .track_remove, .purge_req, .wb_flush_done, .tlb_purge,
   .wb_flush_req, .purge_done, .req_lower_fault);

/* File: testbench/maap_coh_model.sv */
// Coherence side model: drains write buffers on request after a set latency
`timescale 1ns/10ps
module maap_coh_model (
   input wire logic       core_clk,
   input wire logic       srst,
   input wire logic       wb_flush_req,
   input wire logic [3:0] lat,
   output logic           wb_flush_done
);
   logic [3:0] cnt;

   // Done only while asked, dropped once the request falls
   always_ff @(posedge core_clk) begin
      if (srst || !wb_flush_req) begin
         cnt           <= 4'h0;
         wb_flush_done <= 1'b0;
      end else if (cnt == lat)
         wb_flush_done <= 1'b1;
      else
         cnt <= cnt + 4'h1;
   end
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the memory attribute access policy block
`timescale 1ns/10ps
module tb_top;
   import maap_pkg::*;
   localparam logic [7:0] DEF = 8'h80;
   localparam logic [7:0] BS  = 8'h40;
   localparam logic [7:0] MEM = 8'h20;
   localparam logic [7:0] PD  = 8'h10;
   localparam logic [7:0] FLB = 8'h08;
   localparam logic [7:0] ATM = 8'h04;
   localparam logic [7:0] AL  = 8'h02;
   localparam logic [7:0] RM  = 8'h01;
   logic core_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0;
   logic req_ext = 1'b0, req_lower_fault = 1'b0, purge_req = 1'b0;
   logic [REG_AW-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
   maap_op_t   req_op = MAAP_OP_LOAD;
   maap_attr_t req_attr = MAAP_ATTR_WB;
   logic [6:0] req_treg = '0;
   logic [47:0] req_addr = '0;
   logic [3:0] req_size = 4'h8, lat_r = 4'h0;
   maap_fault_t resp_fault;
   logic resp_valid, resp_deferred, resp_base_update, mem_issue, prefetch_drop, flush_bcast;
   logic atomic_export, track_alloc, track_remove, wb_flush_done, tlb_purge, wb_flush_req;
   logic purge_done;
   int n_mismatch = 0, checks_done = 0, i;
   maap_op_t   nap_ops [6] = '{MAAP_OP_FETCH, MAAP_OP_LOAD, MAAP_OP_STORE, MAAP_OP_CMPXCHG,
                               MAAP_OP_XCHG, MAAP_OP_FETCHADD};
   maap_op_t   ext_ops [4] = '{MAAP_OP_LOAD, MAAP_OP_STORE, MAAP_OP_ADV_LD, MAAP_OP_CHK_CLR};
   maap_attr_t oth [4] = '{MAAP_ATTR_WBL, MAAP_ATTR_UC, MAAP_ATTR_XUC, MAAP_ATTR_WC};

   always #2 core_clk = ~core_clk;

   maap_policy uut (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .req_valid, .req_op, .req_attr, .req_ext, .req_lower_fault, .req_treg, .req_addr,
      .req_size, .resp_valid, .resp_fault, .resp_deferred, .resp_base_update, .mem_issue,
      .prefetch_drop, .flush_bcast, .atomic_export, .track_alloc, .track_remove, .purge_req,
      .wb_flush_done, .tlb_purge, .wb_flush_req, .purge_done);
   maap_coh_model coh (.core_clk, .srst, .wb_flush_req, .lat(lat_r), .wb_flush_done);

   task automatic finish_test();
      if (n_mismatch == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge core_clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", e, reg_rdata);
   endtask

   // Flags: deferred, base, mem, drop, flush, export, alloc, remove
   task automatic req(input maap_op_t op, input maap_attr_t at, input logic [6:0] tr,
                      input logic [7:0] ad, input maap_fault_t f, input logic [7:0] fl,
                      input logic [1:0] xl = 2'h0, input logic [10:0] m = 11'h7ff);
      @(posedge core_clk);
      req_valid <= 1'b1; req_op <= op; req_attr <= at; req_treg <= tr;
      req_addr <= {40'h0, ad}; req_ext <= xl[1]; req_lower_fault <= xl[0];
      @(posedge core_clk);
      req_valid <= 1'b0;
      #1;
      chk("response", {1'b1, f, fl} & m, {resp_valid, resp_fault, resp_deferred,
          resp_base_update, mem_issue, prefetch_drop, flush_bcast, atomic_export,
          track_alloc, track_remove} & m);
   endtask

   task automatic purge(input logic [3:0] lat);
      int k;
      @(posedge core_clk);
      lat_r <= lat; purge_req <= 1'b1;
      @(posedge core_clk);
      purge_req <= 1'b0;
      #1;
      chk("tlb_purge", 1, tlb_purge);
      chk("wb_flush_req", 1, wb_flush_req);
      @(posedge core_clk);
      purge_req <= 1'b1;
      @(posedge core_clk);
      purge_req <= 1'b0;
      #1;
      chk("tlb_purge busy", 0, tlb_purge);
      if (lat > 4'h4)
         rd(REG_STATUS, 32'h0000_0001);
      for (k = 0; k < 40 && purge_done !== 1'b1; k++) begin
         @(posedge core_clk);
         #1;
      end
      chk("purge_done", 1, purge_done);
      chk("wb_flush_req off", 0, wb_flush_req);
      @(posedge core_clk);
      #1;
      chk("no second purge", 0, tlb_purge | purge_done);
   endtask

   initial begin
      repeat (5000) @(posedge core_clk);
      n_mismatch++;
      finish_test();
   end

   initial begin
      repeat (12) @(posedge core_clk);
      srst <= 1'b0;
      rd(REG_CTRL, 32'h0000_0000);
      rd(REG_DEFER, 32'h0000_0000);
      wr(REG_STATUS, 32'hffff_ffff);
      rd(REG_STATUS, 32'h0000_0000);
      rd(4'hc, 32'h0000_0000);
      wr(REG_CTRL, 32'h0000_0007);
      rd(REG_CTRL, 32'h0000_0007);
      wr(REG_CTRL, 32'h0000_0000);
      for (i = 0; i < 6; i++)
         req(nap_ops[i], MAAP_ATTR_NAP, 7'h1, 8'h10, MAAP_FLT_NAP, 8'h00, 2'h3);
      req(MAAP_OP_SPEC_LD, MAAP_ATTR_NAP, 7'h1, 8'h10, MAAP_FLT_NONE, DEF | BS);
      req(MAAP_OP_ADV_LD, MAAP_ATTR_WB, 7'h5, 8'h10, MAAP_FLT_NONE, BS | MEM | AL);
      req(MAAP_OP_SADV_LD, MAAP_ATTR_NAP, 7'h5, 8'h10, MAAP_FLT_NONE, DEF | BS | RM);
      rd(REG_STATUS, 32'h0000_0000);
      req(MAAP_OP_LOAD, MAAP_ATTR_WB, 7'h1, 8'h10, MAAP_FLT_LOWER, 8'h00, 2'h1);
      req(MAAP_OP_SPEC_LD, MAAP_ATTR_WB, 7'h1, 8'h10, MAAP_FLT_LOWER, 8'h00, 2'h1);
      req(MAAP_OP_SPEC_LD, MAAP_ATTR_NAP, 7'h1, 8'h10, MAAP_FLT_LOWER, 8'h00, 2'h1);
      wr(REG_DEFER, 32'h0000_0001);
      req(MAAP_OP_SPEC_LD, MAAP_ATTR_WB, 7'h1, 8'h10, MAAP_FLT_NONE, DEF | BS, 2'h1);
      for (i = 0; i < 4; i++)
         req(ext_ops[i], oth[i], 7'h2, 8'h20, (i == 0) ? MAAP_FLT_NONE : MAAP_FLT_UNSUP,
             (i == 0) ? BS | MEM : 8'h00, 2'h2);
      req(MAAP_OP_SPEC_LD, MAAP_ATTR_UC, 7'h2, 8'h20, MAAP_FLT_NONE, DEF | BS, 2'h2);
      req(MAAP_OP_LOAD, MAAP_ATTR_NAP, 7'h2, 8'h20, MAAP_FLT_NAP, 8'h00, 2'h2);
      wr(REG_CTRL, 32'h0000_0001);
      req(MAAP_OP_LOAD, MAAP_ATTR_UC, 7'h2, 8'h20, MAAP_FLT_NONE, BS | MEM, 2'h2);
      req(MAAP_OP_CMPXCHG, MAAP_ATTR_WB, 7'h2, 8'h20, MAAP_FLT_NONE, BS | MEM);
      for (i = 0; i < 4; i++) begin
         req(MAAP_OP_CMPXCHG, oth[i], 7'h2, 8'h20, MAAP_FLT_UNSUP, 8'h00);
         req(MAAP_OP_XCHG, oth[i], 7'h2, 8'h20, MAAP_FLT_UNSUP, 8'h00);
      end
      req(MAAP_OP_FETCHADD, MAAP_ATTR_WB, 7'h2, 8'h20, MAAP_FLT_NONE, BS | MEM);
      for (i = 1; i < 4; i++)
         req(MAAP_OP_FETCHADD, oth[i], 7'h2, 8'h20, MAAP_FLT_UNSUP, 8'h00);
      wr(REG_CTRL, 32'h0000_0002);
      req(MAAP_OP_FETCHADD, MAAP_ATTR_XUC, 7'h2, 8'h20, MAAP_FLT_NONE,
          BS | MEM | ATM);
      req(MAAP_OP_FETCHADD, MAAP_ATTR_WC, 7'h2, 8'h20, MAAP_FLT_UNSUP, 8'h00);
      for (i = 0; i < 6; i++) begin
         req(MAAP_OP_FLUSH, maap_attr_t'(i), 7'h3, 8'h30, MAAP_FLT_NONE, FLB, 2'h0,
             11'h7bf);
         req(MAAP_OP_PREFETCH, maap_attr_t'(i), 7'h3, 8'h30, MAAP_FLT_NONE,
             (i < 2) ? MEM : PD, 2'h0, 11'h7bf);
      end
      purge(4'h0);
      purge(4'h8);
      req(MAAP_OP_ADV_LD, MAAP_ATTR_WB, 7'h1, 8'h10, MAAP_FLT_NONE, BS | MEM | AL);
      req(MAAP_OP_CHK_CLR, MAAP_ATTR_WB, 7'h1, 8'h10, MAAP_FLT_NONE, BS | MEM | RM);
      req(MAAP_OP_CHK_CLR, MAAP_ATTR_WB, 7'h1, 8'h10, MAAP_FLT_NONE, BS | MEM);
      req(MAAP_OP_ADV_LD, MAAP_ATTR_WB, 7'h2, 8'h10, MAAP_FLT_NONE, BS | MEM | AL);
      req(MAAP_OP_ADV_LD, MAAP_ATTR_UC, 7'h2, 8'h10, MAAP_FLT_NONE, BS | MEM | RM);
      req(MAAP_OP_ADV_LD, MAAP_ATTR_WBL, 7'h3, 8'h10, MAAP_FLT_NONE, BS | MEM | AL);
      req(MAAP_OP_SADV_LD, MAAP_ATTR_WBL, 7'h3, 8'h10, MAAP_FLT_NONE, BS | MEM | RM);
      req(MAAP_OP_SADV_LD, MAAP_ATTR_WB, 7'h4, 8'h20, MAAP_FLT_NONE, BS | MEM | AL);
      req(MAAP_OP_CHK_NC, MAAP_ATTR_WB, 7'h4, 8'h20, MAAP_FLT_NONE, BS | MEM);
      req(MAAP_OP_CHK_NC, MAAP_ATTR_WBL, 7'h6, 8'h30, MAAP_FLT_NONE, BS | MEM | AL);
      req(MAAP_OP_CHK_NC, MAAP_ATTR_UC, 7'h7, 8'h30, MAAP_FLT_NONE, BS | MEM);
      req(MAAP_OP_CHK_CLR, MAAP_ATTR_WBL, 7'h6, 8'h30, MAAP_FLT_NONE, BS | MEM | RM);
      rd(REG_STATUS, 32'h0000_0100);
      wr(REG_CTRL, 32'h0000_0004);
      req(MAAP_OP_CHK_NC, MAAP_ATTR_WB, 7'h4, 8'h24, MAAP_FLT_NONE, BS | MEM | AL);
      finish_test();
   end
endmodule
